// ---- e1sup_pkg.sv ----
/*
  Constants, register map and types for the E1 card alarm and status supervisor.
  Assumes a 50 MHz card clock and a 32-bit Avalon-MM register port.
*/
package e1sup_pkg;

  // ***************************************************
  // Timing
  // ***************************************************
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned POLL_LAPSE_MS = 2000;
  localparam int unsigned POLL_LAPSE_CYC = POLL_LAPSE_MS * (CLK_HZ / 1000);
  localparam int unsigned LAPSE_CNT_W = 27;

  // ***************************************************
  // Register offsets (byte addresses)
  // ***************************************************
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h08;
  localparam logic [4:0] OFS_IRQ_CLR = 5'h0c;
  localparam logic [4:0] OFS_IRQ_EN = 5'h10;
  localparam logic [4:0] OFS_COUNTS = 5'h14;
  localparam logic [4:0] OFS_OOF_THR = 5'h18;

  // ***************************************************
  // Control fields
  // ***************************************************
  localparam int CTRL_OOS = 0;
  localparam int CTRL_MAINT = 1;
  localparam int CTRL_MANUAL = 2;
  localparam int CTRL_BASE_SET = 3;
  localparam int CTRL_RST_ACK = 4;
  localparam logic [4:0] CTRL_RESET = 5'h04;

  // ***************************************************
  // Status fields
  // ***************************************************
  localparam int ST_STATE = 0;
  localparam int ST_ALARM = 2;
  localparam int ST_RED = 4;
  localparam int ST_YEL = 5;
  localparam int ST_GRN = 6;
  localparam int ST_YTX = 7;
  localparam int ST_ACCEPT = 8;
  localparam int ST_TEARDOWN = 9;
  localparam int ST_LAPSE = 10;
  localparam int ST_PROTO = 12;
  localparam int ST_SLOT = 16;

  // ***************************************************
  // Interrupt bits and counters
  // ***************************************************
  localparam int IRQ_W = 4;
  localparam int IRQ_RED = 0;
  localparam int IRQ_YEL = 1;
  localparam int IRQ_STATE = 2;
  localparam int IRQ_LAPSE = 3;
  localparam logic [3:0] IRQ_EN_RESET = 4'h0;
  localparam int CNT_W = 16;
  localparam logic [15:0] OOF_THR_RESET = 16'h000a;

  typedef enum logic [1:0] {
    E1SUP_ACTIVE = 2'b00,
    E1SUP_MAINT = 2'b01,
    E1SUP_OOS = 2'b10
  } e1sup_state_t;

  typedef enum logic [1:0] {
    E1SUP_ALM_NONE = 2'b00,
    E1SUP_ALM_MINOR = 2'b01,
    E1SUP_ALM_MAJOR = 2'b10
  } e1sup_alarm_t;

  typedef enum logic [2:0] {
    E1SUP_DSS1 = 3'b000,
    E1SUP_DASS2_NET = 3'b001,
    E1SUP_DASS2_EXCH = 3'b010,
    E1SUP_DPNSS = 3'b011,
    E1SUP_EURO_ISDN = 3'b100
  } e1sup_proto_t;

endpackage

// ---- e1sup_poll_if.sv ----
/*
  Carrier between the supervisor core and its poll lapse timer.
  Assumes both ends run on the single card clock.
*/
`timescale 1ns/100ps

interface e1sup_poll_if;
  logic poll;
  logic lapse;
  modport core (output poll, input lapse);
  modport timer (input poll, output lapse);
endinterface

// ---- e1sup_lapse_timer.sv ----
/*
  Poll lapse timer: counts card clocks since the last controller poll.
  Assumes poll is a one-cycle pulse synchronous to clk.
*/
`timescale 1ns/100ps

module e1sup_lapse_timer
  import e1sup_pkg::*;
#(
  parameter int unsigned LAPSE_CYC = e1sup_pkg::POLL_LAPSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Core side
  e1sup_poll_if.timer pif
);

  import e1sup_pkg::*;

  localparam logic [LAPSE_CNT_W-1:0] LIMIT = LAPSE_CNT_W'(LAPSE_CYC - 1);

  logic [LAPSE_CNT_W-1:0] cnt_q;
  logic lapse_q;
  wire at_limit = (cnt_q == LIMIT);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
      lapse_q <= 1'b0;
    end
    else if (pif.poll)
    begin
      cnt_q <= '0;
      lapse_q <= 1'b0;
    end
    else if (at_limit)
      lapse_q <= 1'b1;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  assign pif.lapse = lapse_q;

  // ***************************************************
  // Checks
  // ***************************************************
  poll_clears_lapse_a: assert property (@(posedge clk) disable iff (!rst_b)
    pif.poll |=> !lapse_q && cnt_q == '0)
    else $error("lapse not cleared by poll");

  lapse_at_limit_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(lapse_q) |-> $past(at_limit) && !$past(pif.poll))
    else $error("lapse rose before limit");

endmodule // e1sup_lapse_timer

// ---- e1sup_top.sv ----
/*
  E1 card alarm and status supervisor: indicators, card state, outward
  yellow alarm, system alarm level, counters, identity and slot capture.
  Assumes span condition inputs are synchronous levels, slip_pulse and
  midnight_pulse are one-cycle pulses, and software uses Avalon-MM.
*/
// How it works
// - Red lights steadily on carrier loss, frame alignment loss or signaling channel failure.
// - Yellow lights on remote alarm or a two second poll lapse; a lapse alone keeps the card active.
// - Green stays lit until software marks the base address assigned and never signals an alarm.
// - With no fault and the base address assigned all indicators are off, the state is active and no system alarm is raised.
// - Carrier loss (major) or frame loss (minor) lights red, enters maintenance (frame loss at threshold if manual) and sends yellow outward.
// - Signaling failure (none) or setup timer expiry (major) lights red, enters maintenance, sends nothing.
// - Remote alarm lights yellow, raises a minor alarm, enters maintenance and sends nothing.
// - After card reset red, yellow and green light, alarm is major and state is maintenance.
// - Out of service lights green, raises a minor alarm and reports the out-of-service state.
// - Commanded maintenance refuses new calls; calls are torn down only on out of service or carrier loss.
// - The card returns to active only once every maintenance cause has cleared.
// - With manual intervention off, frame loss enters and leaves maintenance directly, ignoring the threshold.
// - Slip and frame loss counters clear to zero on each midnight pulse.
// - The override switch selects Euro ISDN; otherwise the two identity switches select the protocol.
`timescale 1ns/100ps

module e1sup_top
  import e1sup_pkg::*;
#(
  parameter int unsigned LAPSE_CYC = e1sup_pkg::POLL_LAPSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM register port
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Span conditions
  input wire logic carrier_lost,
  input wire logic frame_alignment_lost,
  input wire logic remote_alarm,
  input wire logic sig_chan_fail,
  input wire logic setup_timer_expired,
  input wire logic slip_pulse,
  input wire logic midnight_pulse,
  // Straps
  input wire logic variant_override_switch,
  input wire logic identity_switch_high,
  input wire logic identity_switch_low,
  input wire logic [7:0] card_addr,
  // Indicators and span control
  output logic led_red,
  output logic led_yellow,
  output logic led_green,
  output logic yellow_tx,
  output logic [1:0] card_state,
  output logic [1:0] system_alarm,
  output logic call_accept,
  output logic call_teardown,
  output logic irq
);

  import e1sup_pkg::*;

  // ***************************************************
  // Declarations
  // ***************************************************
  e1sup_poll_if pif ();
  logic [4:0] ctrl_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_en_q;
  logic [CNT_W-1:0] oof_cnt_q, slip_cnt_q, oof_thr_q;
  logic [7:0] slot_q;
  logic slot_taken_q;
  logic [2:0] proto_q;
  logic oof_prev_q;
  logic red_q, yel_q, grn_q, ytx_q, accept_q, tear_q, irq_q;
  e1sup_state_t state_q, state_d;
  e1sup_alarm_t alarm_q, alarm_d;
  logic [31:0] rdata_q;
  logic wait_q;

  // ***************************************************
  // Bus decode
  // ***************************************************
  wire req = avs_read | avs_write;
  wire done = req & ~wait_q;
  wire wr_en = avs_write & done;
  wire wr_ctrl = wr_en & (avs_address == OFS_CTRL);
  wire wr_clr = wr_en & (avs_address == OFS_IRQ_CLR);
  wire wr_en_reg = wr_en & (avs_address == OFS_IRQ_EN);
  wire wr_thr = wr_en & (avs_address == OFS_OOF_THR);

  // ***************************************************
  // Conditions
  // ***************************************************
  wire oos_cmd = ctrl_q[CTRL_OOS];
  wire maint_cmd = ctrl_q[CTRL_MAINT];
  wire manual_on = ctrl_q[CTRL_MANUAL];
  wire base_set = ctrl_q[CTRL_BASE_SET];
  wire reset_pend = ~ctrl_q[CTRL_RST_ACK];
  wire lapse = pif.lapse;
  wire oof_rise = frame_alignment_lost & ~oof_prev_q;
  wire oof_maint = frame_alignment_lost & (~manual_on | (oof_cnt_q >= oof_thr_q));
  wire maint_any = carrier_lost | oof_maint | sig_chan_fail | setup_timer_expired
                 | remote_alarm | reset_pend | maint_cmd;
  wire red_d = carrier_lost | frame_alignment_lost | sig_chan_fail | setup_timer_expired | reset_pend;
  wire yel_d = remote_alarm | lapse | reset_pend;
  // Green until base assigned, plus out of service
  wire grn_d = ~base_set | oos_cmd;
  // Outward yellow on carrier or frame loss
  wire ytx_d = carrier_lost | frame_alignment_lost;
  wire major = carrier_lost | setup_timer_expired | reset_pend;
  wire minor = frame_alignment_lost | remote_alarm | lapse | oos_cmd;
  // Teardown only on out of service or carrier loss
  wire tear_d = oos_cmd | carrier_lost;
  wire [IRQ_W-1:0] ev = {lapse & ~pif.poll & ~irq_stat_q[IRQ_LAPSE],
                         state_d != state_q, yel_d & ~yel_q, red_d & ~red_q};
  wire [2:0] proto_d = variant_override_switch ? E1SUP_EURO_ISDN
                     : {1'b0, identity_switch_high, identity_switch_low};

  // Out of service wins, else active when clear
  always_comb
  begin
    if (oos_cmd)
      state_d = E1SUP_OOS;
    else if (maint_any)
      state_d = E1SUP_MAINT;
    else
      state_d = E1SUP_ACTIVE;
    // Signaling failure raises no alarm by itself
    if (major)
      alarm_d = E1SUP_ALM_MAJOR;
    else if (minor)
      alarm_d = E1SUP_ALM_MINOR;
    else
      alarm_d = E1SUP_ALM_NONE;
  end

  // ***************************************************
  // Status outputs
  // ***************************************************
  // Registered causes, reset view
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      red_q <= 1'b1;
      yel_q <= 1'b1;
      grn_q <= 1'b1;
      ytx_q <= 1'b0;
      state_q <= E1SUP_MAINT;
      alarm_q <= E1SUP_ALM_MAJOR;
      accept_q <= 1'b0;
      tear_q <= 1'b0;
    end
    else
    begin
      red_q <= red_d;
      yel_q <= yel_d;
      grn_q <= grn_d;
      ytx_q <= ytx_d;
      state_q <= state_d;
      alarm_q <= alarm_d;
      accept_q <= (state_d == E1SUP_ACTIVE);
      tear_q <= tear_d;
    end
  end

  // Slot taken once after release, identity every cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      slot_q <= 8'h00;
      slot_taken_q <= 1'b0;
      proto_q <= 3'h0;
    end
    else
    begin
      proto_q <= proto_d;
      if (!slot_taken_q)
      begin
        slot_q <= card_addr;
        slot_taken_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      oof_cnt_q <= '0;
      slip_cnt_q <= '0;
      oof_prev_q <= 1'b0;
    end
    else
    begin
      oof_prev_q <= frame_alignment_lost;
      if (midnight_pulse)
      begin
        oof_cnt_q <= '0;
        slip_cnt_q <= '0;
      end
      else
      begin
        if (oof_rise && oof_cnt_q != '1)
          oof_cnt_q <= oof_cnt_q + 1'b1;
        if (slip_pulse && slip_cnt_q != '1)
          slip_cnt_q <= slip_cnt_q + 1'b1;
      end
    end
  end

  // ***************************************************
  // Registers and interrupts
  // ***************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_q <= CTRL_RESET;
      irq_en_q <= IRQ_EN_RESET;
      oof_thr_q <= OOF_THR_RESET;
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= avs_writedata[4:0];
      if (wr_en_reg)
        irq_en_q <= avs_writedata[IRQ_W-1:0];
      if (wr_thr)
        oof_thr_q <= avs_writedata[CNT_W-1:0];
      // Set wins over clear so no event is lost
      irq_stat_q <= (irq_stat_q & ~({IRQ_W{wr_clr}} & avs_writedata[IRQ_W-1:0])) | ev;
      irq_q <= |(irq_stat_q & irq_en_q);
    end
  end

  // One wait cycle lets read data come from a register
  wire [31:0] status_w = {8'h00, slot_q, 1'b0, proto_q, 1'b0, lapse, tear_q, accept_q,
                          ytx_q, grn_q, yel_q, red_q, alarm_q, state_q};
  wire [31:0] rmux = (avs_address == OFS_CTRL) ? {27'h0, ctrl_q}
                   : (avs_address == OFS_STATUS) ? status_w
                   : (avs_address == OFS_IRQ_STAT) ? {28'h0, irq_stat_q}
                   : (avs_address == OFS_IRQ_EN) ? {28'h0, irq_en_q}
                   : (avs_address == OFS_COUNTS) ? {slip_cnt_q, oof_cnt_q}
                   : (avs_address == OFS_OOF_THR) ? {16'h0, oof_thr_q}
                   : 32'h0;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end
    else
    begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q)
        rdata_q <= rmux;
    end
  end

  // Every completed access counts as a poll
  assign pif.poll = done;

  e1sup_lapse_timer #(.LAPSE_CYC(LAPSE_CYC)) u_lapse (
    .clk(clk),
    .rst_b(rst_b),
    .pif(pif)
  );

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign led_red = red_q;
  assign led_yellow = yel_q;
  assign led_green = grn_q;
  assign yellow_tx = ytx_q;
  assign card_state = state_q;
  assign system_alarm = alarm_q;
  assign call_accept = accept_q;
  assign call_teardown = tear_q;
  assign irq = irq_q;

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  red_follows_a: assert property (carrier_lost || sig_chan_fail |=> led_red)
    else $error("red not lit");
  lapse_keeps_a: assert property (lapse && !maint_any && !oos_cmd |=> card_state == E1SUP_ACTIVE)
    else $error("lapse changed state");
  green_base_a: assert property (!base_set |=> led_green)
    else $error("green off before base");
  idle_dark_a: assert property (!red_d && !yel_d && !grn_d && state_d == E1SUP_ACTIVE
    |=> !led_red && !led_yellow && !led_green && system_alarm == E1SUP_ALM_NONE)
    else $error("indicator lit with no fault");
  carrier_maint_a: assert property (carrier_lost && !oos_cmd
    |=> card_state == E1SUP_MAINT && yellow_tx && system_alarm == E1SUP_ALM_MAJOR)
    else $error("carrier loss not handled");
  no_tx_sig_a: assert property (!carrier_lost && !frame_alignment_lost |=> !yellow_tx)
    else $error("yellow sent without cause");
  remote_minor_a: assert property (remote_alarm && !major && !oos_cmd
    |=> led_yellow && system_alarm == E1SUP_ALM_MINOR && card_state == E1SUP_MAINT)
    else $error("remote alarm not handled");
  reset_view_a: assert property (reset_pend |=> led_red && led_yellow && system_alarm == E1SUP_ALM_MAJOR)
    else $error("reset indication wrong");
  oos_state_a: assert property (oos_cmd |=> card_state == E1SUP_OOS && led_green && call_teardown)
    else $error("out of service wrong");
  maint_refuse_a: assert property (maint_cmd |=> !call_accept)
    else $error("calls accepted in maintenance");
  active_clear_a: assert property (card_state == E1SUP_ACTIVE |-> !$past(maint_any))
    else $error("active while cause held");
  oof_direct_a: assert property (!manual_on && frame_alignment_lost && !oos_cmd
    |=> card_state == E1SUP_MAINT)
    else $error("frame loss ignored");
  midnight_zero_a: assert property (midnight_pulse |=> oof_cnt_q == '0 && slip_cnt_q == '0)
    else $error("counters not cleared");
  proto_decode_a: assert property (variant_override_switch |=> proto_q == E1SUP_EURO_ISDN)
    else $error("override ignored");
  slot_hold_a: assert property (slot_taken_q |=> $stable(slot_q))
    else $error("slot changed");
  irq_level_a: assert property (|(irq_stat_q & irq_en_q) |=> irq)
    else $error("irq not raised");

endmodule // e1sup_top

// ---- e1sup_ctrl_model.sv ----
/*
  System controller model: polls the supervisor as an Avalon-MM master.
  Assumes a single card clock and a slave that lowers waitrequest to answer.
*/
`timescale 1ns/100ps

module e1sup_ctrl_model (
  // Clock
  input wire logic clk,
  // Avalon-MM master side
  output logic [4:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Hang flag
  output logic stuck
);
  initial
  begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    stuck = 1'b0;
  end

  // ***************************************************
  // Bus cycle
  // ***************************************************
  // Released lines are scrambled so no stale value can pass for a good one
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d, input int gap);
    int n;
    begin
      n = 0;
      repeat (gap) @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 64);
      if (n >= 64)
        stuck <= 1'b1;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_address <= ~a;
      avs_writedata <= ~d;
    end
  endtask
endmodule // e1sup_ctrl_model

// ---- e1sup_top_tb.sv ----
/*
  Self-checking bench for the E1 card supervisor: reads are noted in a queue
  and checked when they complete. Assumes a 50 MHz clock and LAPSE_CYC of 200.
*/
`timescale 1ns/100ps
`define CHECK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module e1sup_top_tb;
  import e1sup_pkg::*;
  localparam int unsigned LAPSE = 200;
  localparam logic [31:0] M = 32'h000007ff;
  typedef struct { string nm; logic [31:0] e; logic [31:0] m; } e1sup_note_t;
  e1sup_note_t notes[$];
  e1sup_note_t nt;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] cond = 5'h00;
  logic [2:0] sw = 3'h0;
  logic slip = 1'b0;
  logic midn = 1'b0;
  logic [7:0] addr0;
  logic [7:0] card_addr;
  logic [4:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, stuck;
  logic [31:0] avs_writedata, avs_readdata;
  logic led_red, led_yellow, led_green, yellow_tx, call_accept, call_teardown, irq;
  logic [1:0] card_state, system_alarm;
  int mismatches = 0;
  int n_checks = 0;
  int n;
  logic [4:0] tc [8] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h14, 5'h04, 5'h00};
  logic [31:0] te [8] = '{32'h299, 32'h095, 32'h025, 32'h011, 32'h019, 32'h2b9, 32'h025, 32'h100};

  always #10 clk = ~clk;

  e1sup_top #(.LAPSE_CYC(LAPSE)) u_e1sup_top (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .carrier_lost(cond[4]), .frame_alignment_lost(cond[3]),
    .remote_alarm(cond[2]), .sig_chan_fail(cond[1]), .setup_timer_expired(cond[0]), .slip_pulse(slip),
    .midnight_pulse(midn), .variant_override_switch(sw[2]), .identity_switch_high(sw[1]),
    .identity_switch_low(sw[0]), .card_addr(card_addr), .led_red(led_red), .led_yellow(led_yellow),
    .led_green(led_green), .yellow_tx(yellow_tx), .card_state(card_state), .system_alarm(system_alarm),
    .call_accept(call_accept), .call_teardown(call_teardown), .irq(irq));

  e1sup_ctrl_model u_e1sup_ctrl_model (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stuck(stuck));

  // ***************************************************
  // Verdict and monitor
  // ***************************************************
  task automatic complete_run;
    begin
      if (mismatches == 0 && n_checks > 0)
      begin
        $display("Regression OK");
      end
      else
      begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask

  always @(posedge stuck)
  begin
    mismatches++;
    complete_run();
  end

  // Read data stand from the edge before the completing edge until the next access, so they are taken at the completing edge
  always @(posedge clk)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      nt = notes.pop_front();
      `CHECK(nt.nm, nt.e, avs_readdata & nt.m)
    end
  end

  // ***************************************************
  // Stimulus tasks
  // ***************************************************
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    u_e1sup_ctrl_model.xfer(1'b1, a, d, 1 + $urandom_range(2));
  endtask

  task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    begin
      notes.push_back('{nm, e, m});
      u_e1sup_ctrl_model.xfer(1'b0, a, 32'h00000000, 1 + $urandom_range(2));
    end
  endtask

  task automatic settle(input logic [4:0] v);
    begin
      @(posedge clk);
      cond <= v;
      repeat (3) @(posedge clk);
    end
  endtask

  task automatic pulse(input logic m);
    begin
      @(posedge clk);
      if (m)
        midn <= 1'b1;
      else
        slip <= 1'b1;
      @(posedge clk);
      midn <= 1'b0;
      slip <= 1'b0;
    end
  endtask

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial
  begin
    void'($urandom(82705));
    addr0 = 8'($urandom());
    card_addr = addr0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd("status after reset", OFS_STATUS, 32'h079 | (32'(addr0) << 16), 32'h00ff77ff);
    card_addr <= ~addr0;
    wr(OFS_CTRL, 32'h0000000c);
    rd("reset indication", OFS_STATUS, 32'h039, M);
    wr(OFS_CTRL, 32'h0000001c);
    rd("idle status", OFS_STATUS, 32'h100, M);
    wr(OFS_OOF_THR, 32'h00000002);
    rd("frame threshold", OFS_OOF_THR, 32'h00000002, 32'h0000ffff);
    settle(5'h08);
    rd("frame below threshold", OFS_STATUS, 32'h090, 32'h093);
    settle(5'h00);
    wr(OFS_CTRL, 32'h00000018);
    for (int i = 0; i < 8; i++)
    begin
      settle(tc[i]);
      rd("span table", OFS_STATUS, te[i], M);
      `CHECK("red pin", te[i][ST_RED], led_red)
      `CHECK("yellow out pin", te[i][ST_YTX], yellow_tx)
      `CHECK("accept pin", te[i][ST_ACCEPT], call_accept)
      `CHECK("teardown pin", te[i][ST_TEARDOWN], call_teardown)
      `CHECK("green pin", 1'b0, led_green)
    end
    wr(OFS_CTRL, 32'h0000001a);
    rd("commanded maintenance", OFS_STATUS, 32'h001, 32'h303);
    wr(OFS_CTRL, 32'h00000019);
    rd("out of service", OFS_STATUS, 32'h246, M);
    wr(OFS_CTRL, 32'h00000018);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      sw <= 3'(i);
      @(posedge clk);
      rd("protocol", OFS_STATUS, {8'h00, addr0, 1'b0, (i > 3) ? 3'h4 : 3'(i), 12'h000}, 32'h00ff7000);
    end
    pulse(1'b1);
    n = 1 + $urandom_range(5);
    repeat (n) pulse(1'b0);
    repeat (2)
    begin
      settle(5'h08);
      settle(5'h00);
    end
    rd("counters", OFS_COUNTS, {16'(n), 16'h0002}, 32'hffffffff);
    wr(OFS_CTRL, 32'h0000001c);
    settle(5'h08);
    rd("frame at threshold", OFS_STATUS, 32'h095, M);
    settle(5'h00);
    wr(OFS_CTRL, 32'h00000018);
    pulse(1'b1);
    rd("counters at midnight", OFS_COUNTS, 32'h00000000, 32'hffffffff);
    wr(OFS_IRQ_CLR, 32'h0000000f);
    wr(OFS_IRQ_EN, 32'h00000001);
    settle(5'h10);
    rd("red event", OFS_IRQ_STAT, 32'h00000001, 32'h00000001);
    `CHECK("irq enabled", 1'b1, irq)
    wr(OFS_IRQ_EN, 32'h00000000);
    repeat (2) @(posedge clk);
    `CHECK("irq masked", 1'b0, irq)
    settle(5'h00);
    wr(OFS_IRQ_CLR, 32'h00000001);
    rd("event cleared", OFS_IRQ_STAT, 32'h00000000, 32'h00000001);
    rd("clear register", OFS_IRQ_CLR, 32'h00000000, 32'hffffffff);
    wr(5'h1c, 32'hffffffff);
    rd("unmapped", 5'h1c, 32'h00000000, 32'hffffffff);
    // Poll lapse: only the bench is silent, so the timer must fire on its own
    repeat (LAPSE - 10) @(posedge clk);
    `CHECK("yellow before lapse", 1'b0, led_yellow)
    n = 0;
    while (led_yellow !== 1'b1 && n < 30)
    begin
      @(posedge clk);
      n++;
    end
    `CHECK("yellow on lapse", 1'b1, led_yellow)
    `CHECK("state on lapse", E1SUP_ACTIVE, card_state)
    `CHECK("alarm on lapse", E1SUP_ALM_MINOR, system_alarm)
    rd("first poll", OFS_STATUS, 32'h00000420, 32'h00000420);
    rd("lapse cleared", OFS_STATUS, 32'h00000000, 32'h00000420);
    repeat (2) @(posedge clk);
    complete_run();
  end
endmodule // e1sup_top_tb
